// File: src/sar_pkg.sv
// Shared constants and types for the successive-approximation register.
// Assumes a single system clock; no software-visible registers exist.
package sar_pkg;
  // ----------------------------------------------------------------
  // Widths and result constants
  // ----------------------------------------------------------------
  localparam int RESULT_W = 8; // Parallel result width
  localparam int IDX_W = 3; // Trial index width
  localparam logic [IDX_W-1:0] MSB_IDX = 3'h7; // First bit tried
  localparam logic [IDX_W-1:0] LSB_IDX = 3'h0; // Last bit tried
  localparam logic [RESULT_W-1:0] RESULT_CLEAR = 8'h00; // Cleared result
  localparam logic [RESULT_W-1:0] MSB_ONLY = 8'h80; // Value right after start

  // ----------------------------------------------------------------
  // Input synchroniser lanes
  // ----------------------------------------------------------------
  localparam int SYNC_W = 3; // Number of synchronised pins
  localparam int LANE_TRIG = 0; // Conversion trigger lane
  localparam int LANE_COMP = 1; // Comparator decision lane
  localparam int LANE_CTRL = 2; // Shared control pin lane
  localparam logic [SYNC_W-1:0] SYNC_RESET = 3'h0; // Pins assumed low at reset

  // ----------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_CLEARED = 3'h1, // Register cleared, waiting for a start
    ST_TRIAL = 3'h2, // Bit trials under way
    ST_DONE = 3'h4 // Result held, conversion complete
  } state_t;

  // Mask with only the given result bit set
  function automatic logic [RESULT_W-1:0] bit_mask(input logic [IDX_W-1:0] idx);
    bit_mask = RESULT_W'(1) << idx;
  endfunction : bit_mask
endpackage : sar_pkg

// File: src/pin_sync.sv
// Three-stage input synchroniser with agreement filter for the converter pins.
// Assumes the pins are asynchronous to clk_sys.
`timescale 1ns/100ps
module pin_sync (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic [sar_pkg::SYNC_W-1:0] pins_in, // Raw pin levels
  output logic [sar_pkg::SYNC_W-1:0] pins_out // Filtered, synchronous levels
);
  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  logic [sar_pkg::SYNC_W-1:0] meta_q; // First stage, read only by stage two
  logic [sar_pkg::SYNC_W-1:0] stage2_q; // Second stage
  logic [sar_pkg::SYNC_W-1:0] stage3_q; // Third stage

  // Shift chain; the first stage may go metastable
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_q <= sar_pkg::SYNC_RESET;
      stage2_q <= sar_pkg::SYNC_RESET;
      stage3_q <= sar_pkg::SYNC_RESET;
    end else begin
      meta_q <= pins_in;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  // ----------------------------------------------------------------
  // Agreement filter
  // ----------------------------------------------------------------
  // A lane only changes once stages two and three agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pins_out <= sar_pkg::SYNC_RESET;
    end else begin
      for (int i = 0; i < sar_pkg::SYNC_W; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          pins_out[i] <= stage3_q[i];
        end
      end
    end
  end
endmodule : pin_sync

// File: src/successive_approx_register.sv
// Successive-approximation register: sequencing, result storage, done flag
// and serial output for an eight-bit analog-to-digital conversion.
// Assumes an external DAC on result_bits and a comparator on comparator_in.
`timescale 1ns/100ps
module successive_approx_register #(
  parameter bit FEED_FORWARD = 1'b1 // 1: control pin is the tap, 0: master clear
) (
  input wire logic clk_sys, // System clock, 10 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic conversion_trigger, // Start pin
  input wire logic comparator_in, // Comparator decision
  input wire logic control_pin, // Master clear or shortening tap
  output logic [sar_pkg::RESULT_W-1:0] result_bits, // Parallel result to the DAC
  output logic conversion_done, // End of conversion, falling-edge timed
  output logic serial_out, // Serial result stream
  output logic serial_inhibit // High while serial_out is inhibited
);
  // ----------------------------------------------------------------
  // Input capture
  // ----------------------------------------------------------------
  logic [sar_pkg::SYNC_W-1:0] pins_s; // Synchronised pins
  logic trig_s; // Trigger, synchronous
  logic comp_s; // Comparator, synchronous
  logic clear_s; // Master clear, clear variant only
  logic short_s; // Shortening tap, tap variant only
  logic trig_prev_q; // Trigger at the previous edge

  // All pins sampled on the rising edge only
  pin_sync u_pin_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pins_in({control_pin, comparator_in, conversion_trigger}),
    .pins_out(pins_s)
  );

  assign trig_s = pins_s[sar_pkg::LANE_TRIG];
  assign comp_s = pins_s[sar_pkg::LANE_COMP];
  assign clear_s = !FEED_FORWARD && pins_s[sar_pkg::LANE_CTRL];
  assign short_s = FEED_FORWARD && pins_s[sar_pkg::LANE_CTRL];

  // Previous trigger level for edge detection
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_s;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer control
  // ----------------------------------------------------------------
  sar_pkg::state_t state_q; // Sequencer state
  logic [sar_pkg::IDX_W-1:0] idx_q; // Bit under trial
  logic done_pend_q; // Done, rising-edge copy
  logic ninth_q; // Ninth serial bit still owed
  logic start_evt; // Start this edge
  logic advance; // Trial step this edge
  logic finish; // Last trial this edge

  // Start decode; retriggerable in both variants
  always_comb begin
    if (FEED_FORWARD) begin
      // Rising trigger, or trigger high while done
      start_evt = trig_s && (!trig_prev_q || done_pend_q);
    end else begin
      // Cleared register starts on a trigger level
      start_evt = !clear_s && trig_s && (!trig_prev_q || state_q == sar_pkg::ST_CLEARED);
    end
  end

  // Clear variant stalls with trigger low; tap variant never does
  assign advance = state_q == sar_pkg::ST_TRIAL && !clear_s && !start_evt && (FEED_FORWARD || trig_s);
  // Tap high counts as completion
  assign finish = advance && (idx_q == sar_pkg::LSB_IDX || short_s);

  // State and trial index
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q <= sar_pkg::ST_CLEARED;
      idx_q <= sar_pkg::MSB_IDX;
    end else if (clear_s) begin
      state_q <= sar_pkg::ST_CLEARED;
      idx_q <= sar_pkg::MSB_IDX;
    end else if (start_evt) begin
      state_q <= sar_pkg::ST_TRIAL;
      idx_q <= sar_pkg::MSB_IDX;
    end else if (finish) begin
      state_q <= sar_pkg::ST_DONE;
    end else if (advance) begin
      idx_q <= idx_q - 3'h1; // One bit per clock, downward
    end
  end

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  // Trial bit decided by comparator, next bit raised
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      result_bits <= sar_pkg::RESULT_CLEAR;
    end else if (clear_s) begin
      result_bits <= sar_pkg::RESULT_CLEAR;
    end else if (start_evt) begin
      result_bits <= sar_pkg::MSB_ONLY;
    end else if (advance) begin
      if (!comp_s) begin
        result_bits <= result_bits & ~sar_pkg::bit_mask(idx_q);
      end
      // No next bit is raised at a shortened end, so the lower bits stay cleared
      if (idx_q != sar_pkg::LSB_IDX && !finish) begin
        result_bits <= (comp_s ? result_bits : result_bits & ~sar_pkg::bit_mask(idx_q))
          | sar_pkg::bit_mask(idx_q - 3'h1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Done flag
  // ----------------------------------------------------------------
  // Rising-edge copy of completion
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      done_pend_q <= 1'b0;
    end else if (clear_s || start_evt) begin
      done_pend_q <= 1'b0;
    end else if (finish) begin
      done_pend_q <= 1'b1;
    end
  end

  // Output moves on the falling edge to let the result settle first
  always_ff @(negedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      conversion_done <= 1'b0;
    end else begin
      conversion_done <= done_pend_q;
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Bit under decision appears serially in the following period
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serial_out <= 1'b0;
      serial_inhibit <= 1'b1;
      ninth_q <= 1'b0;
    end else if (clear_s || start_evt) begin
      serial_out <= 1'b0; // Inhibited while cleared and first period
      serial_inhibit <= 1'b1;
      ninth_q <= 1'b0;
    end else if (advance) begin
      serial_out <= comp_s;
      serial_inhibit <= 1'b0;
      ninth_q <= finish;
    end else if (ninth_q) begin
      serial_out <= comp_s; // Ninth bit, one cycle after done
      serial_inhibit <= 1'b0;
      ninth_q <= 1'b0;
    end else if (state_q == sar_pkg::ST_DONE) begin
      serial_out <= 1'b0; // Second cycle after done
      serial_inhibit <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_start;
    start_evt;
  endsequence

  sequence s_eight_steps;
    (advance && !short_s) [*8];
  endsequence

  chk_start_sets_msb: assert property (s_start |=> result_bits == sar_pkg::MSB_ONLY && state_q == sar_pkg::ST_TRIAL)
    else $error("start did not load first trial");
  chk_clear_zeroes: assert property (clear_s |=> result_bits == sar_pkg::RESULT_CLEAR && !done_pend_q)
    else $error("master clear did not zero result");
  chk_clear_waits: assert property (!FEED_FORWARD && state_q == sar_pkg::ST_CLEARED && !trig_s |=> state_q == sar_pkg::ST_CLEARED)
    else $error("cleared register left without trigger");
  chk_trial_decision: assert property (advance |=> result_bits[$past(idx_q)] == $past(comp_s))
    else $error("trial bit does not follow comparator");
  chk_full_length: assert property (s_start ##1 s_eight_steps |=> done_pend_q && state_q == sar_pkg::ST_DONE)
    else $error("full conversion not done after eight trials");
  chk_shorten_ends: assert property (advance && short_s |=> state_q == sar_pkg::ST_DONE && done_pend_q)
    else $error("tap did not end conversion");
  chk_done_falling: assert property ($rose(done_pend_q) |-> conversion_done && !$past(conversion_done))
    else $error("done not raised on following falling edge");
  chk_serial_bit: assert property (advance |=> serial_out == $past(comp_s) && !serial_inhibit)
    else $error("serial bit differs from decided bit");
  chk_serial_first: assert property (s_start |=> serial_inhibit && !serial_out)
    else $error("serial not inhibited in first period");
  chk_ninth_then_inh: assert property (
      $rose(done_pend_q) && !start_evt && !clear_s ##1 !start_evt && !clear_s |-> !serial_inhibit ##1 serial_inhibit)
    else $error("ninth bit or following inhibit wrong");
  chk_retrigger: assert property (FEED_FORWARD && done_pend_q && trig_s |=> state_q == sar_pkg::ST_TRIAL)
    else $error("tap variant did not retrigger");
  chk_bits_hold: assert property (state_q == sar_pkg::ST_DONE && !start_evt && !clear_s |=> $stable(result_bits))
    else $error("result changed after completion");
  chk_keeps_moving: assert property (
      state_q == sar_pkg::ST_TRIAL && !clear_s && (FEED_FORWARD || trig_s) |=> idx_q != $past(idx_q) || state_q != sar_pkg::ST_TRIAL || $past(start_evt))
    else $error("sequence rested while not done");
endmodule : successive_approx_register

// File: tb/comparator_model.sv
// Behavioural comparator and DAC facing the register's parallel result.
// Assumes an ideal DAC: one step per code, no settling time.
`timescale 1ns/100ps
module comparator_model (
  input wire logic [sar_pkg::RESULT_W-1:0] result_bits, // Code applied to the DAC
  input wire logic signed [9:0] analog_level, // Input in DAC steps
  input wire logic early_end, // Bench request to shorten the run
  output logic comparator_in, // 1 keeps the bit under trial
  output logic length_shortening_tap // Drives the shared control pin
);
  // ----------------------------------------------------------------
  // Decision and tap
  // ----------------------------------------------------------------
  // Levels outside the code range force one answer for every code
  assign comparator_in = ($signed({2'h0, result_bits}) <= analog_level);
  // Bench raises the tap where a tie to the lowest used bit would
  // Stays low unless the bench asks for a short run
  assign length_shortening_tap = early_end;
endmodule : comparator_model

// File: tb/successive_approx_register_test.sv
// Self-checking bench: tap variant (index 0) and clear variant (index 1).
// Assumes pin latency of about five edges, so waits for outputs are bounded.
`timescale 1ns/100ps
module successive_approx_register_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0; // 10 MHz clock
  logic rstn = 1'b0; // Reset, active low
  logic [1:0] trig = 2'h0; // Trigger per variant
  logic [1:0] ctrl; // Control pin per variant
  logic [1:0] done, sout, inh; // Outputs per variant
  logic [7:0] res [2]; // Results per variant
  logic signed [9:0] analog = 10'h100; // Comparator input level
  logic early = 1'b0; // Shorten request
  logic comp; // Comparator decision, shared
  logic mclr = 1'b0; // Master clear drive
  int n_errors = 0; // Mismatches
  int n_tests = 0; // Comparisons
  int cyc = 0; // Timeout counter

  always #50 clk_sys = ~clk_sys;
  assign ctrl[1] = mclr;

  // ----------------------------------------------------------------
  // Design and partner
  // ----------------------------------------------------------------
  comparator_model comparator_model_inst (.result_bits(res[0]), .analog_level(analog),
    .early_end(early), .comparator_in(comp), .length_shortening_tap(ctrl[0]));
  successive_approx_register #(.FEED_FORWARD(1'b1)) successive_approx_register_inst (.clk_sys(clk_sys),
    .rstn(rstn), .conversion_trigger(trig[0]), .comparator_in(comp), .control_pin(ctrl[0]),
    .result_bits(res[0]), .conversion_done(done[0]), .serial_out(sout[0]), .serial_inhibit(inh[0]));
  // Second instance; name departs from the house form since two are needed
  successive_approx_register #(.FEED_FORWARD(1'b0)) successive_approx_register_mc_inst (.clk_sys(clk_sys),
    .rstn(rstn), .conversion_trigger(trig[1]), .comparator_in(comp), .control_pin(ctrl[1]),
    .result_bits(res[1]), .conversion_done(done[1]), .serial_out(sout[1]), .serial_inhibit(inh[1]));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Compare and count; case inequality so unknowns fail
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Low then high, each long enough to pass the synchroniser
  task automatic start(input int v);
    @(negedge clk_sys);
    trig[v] = 1'b0;
    repeat (6) @(negedge clk_sys);
    trig[v] = 1'b1;
  endtask : start

  // Wait for the start edge, when the top bit alone is set
  task automatic wait_e0(input int v);
    for (int i = 0; i < 14 && res[v] !== 8'h80; i++) begin
      @(posedge clk_sys);
      #10;
    end
  endtask : wait_e0

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Full run with every decision equal to c, edge by edge
  task automatic full_run(input int v, input logic c);
    logic [7:0] e;
    analog = c ? 10'h100 : 10'h3FF;
    start(v);
    wait_e0(v);
    chk("start value", 8'h80, res[v]);
    chk("first inhibit", 8'h01, 8'(inh[v]));
    for (int k = 1; k <= 8; k++) begin
      @(posedge clk_sys);
      #10;
      e = c ? ~(8'hFF >> k) : 8'h00;
      if (k < 8) e = e | (8'h80 >> k);
      chk("trial bits", e, res[v]);
      chk("serial bit", 8'(c), 8'(sout[v]));
      chk("inhibit off", 8'h00, 8'(inh[v]));
      chk("done early", 8'h00, 8'(done[v]));
      // Tap variant keeps going with the trigger low
      if (k == 1 && v == 0) begin
        @(negedge clk_sys);
        trig[0] = 1'b0;
      end
    end
    @(negedge clk_sys);
    #10;
    chk("done rise", 8'h01, 8'(done[v]));
    @(posedge clk_sys);
    #10;
    chk("ninth bit", 8'(c), 8'(sout[v]));
    chk("ninth open", 8'h00, 8'(inh[v]));
    @(posedge clk_sys);
    #10;
    chk("inhibit back", 8'h01, 8'(inh[v]));
    chk("serial low", 8'h00, 8'(sout[v]));
    repeat (3) @(posedge clk_sys);
    #10;
    chk("result held", e, res[v]);
    chk("done held", 8'h01, 8'(done[v]));
    $display("test full_run variant %0d level %0d done", v, c);
  endtask : full_run

  // Tap variant: trigger held high recirculates after the end
  task automatic recirculate;
    start(0);
    for (int i = 0; i < 30 && done[0] !== 1'b1; i++) begin
      @(negedge clk_sys);
      #10;
    end
    chk("first end", 8'h01, 8'(done[0]));
    wait_e0(0);
    chk("restart", 8'h80, res[0]);
    @(negedge clk_sys);
    trig[0] = 1'b0;
    #10;
    chk("done cleared", 8'h00, 8'(done[0]));
    $display("test recirculate done");
  endtask : recirculate

  // Tap variant: a high tap ends the run before eight trials
  task automatic shorten;
    start(0);
    wait_e0(0);
    @(negedge clk_sys);
    trig[0] = 1'b0;
    early = 1'b1;
    repeat (7) @(negedge clk_sys);
    #10;
    chk("short end", 8'h01, 8'(done[0]));
    early = 1'b0;
    $display("test shorten done");
  endtask : shorten

  // Clear variant: stall, clear, hold cleared, restart
  task automatic clear_variant;
    start(1);
    wait_e0(1);
    @(negedge clk_sys);
    trig[1] = 1'b0;
    repeat (12) @(negedge clk_sys);
    chk("stalled", 8'h00, 8'(done[1]));
    mclr = 1'b1;
    repeat (7) @(negedge clk_sys);
    chk("cleared bits", 8'h00, res[1]);
    chk("cleared inhibit", 8'h01, 8'(inh[1]));
    mclr = 1'b0;
    repeat (7) @(negedge clk_sys);
    chk("stay cleared", 8'h00, res[1]);
    trig[1] = 1'b1;
    wait_e0(1);
    chk("clear restart", 8'h80, res[1]);
    $display("test clear_variant done");
  endtask : clear_variant

  // ----------------------------------------------------------------
  // Closing and main sequence
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  // Ceiling well above the roughly 200 cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    #10;
    chk("reset bits", 8'h00, res[0] | res[1]);
    chk("reset inhibit", 8'h03, 8'(inh));
    chk("reset done", 8'h00, 8'(done));
    @(negedge clk_sys);
    rstn = 1'b1;
    full_run(0, 1'b1);
    full_run(0, 1'b0);
    full_run(1, 1'b1);
    full_run(1, 1'b0);
    recirculate();
    shorten();
    clear_variant();
    close_out();
  end
endmodule : successive_approx_register_test
